// *** shared/apbws_pkg.sv ***
// constants, register map and state carriers of the power button and wake status block
package apbws_pkg;
   // register offsets inside the power management block
   localparam logic [4:0] OFS_STATUS = 5'h01;
   localparam logic [4:0] OFS_EN_RSVD = 5'h02;
   localparam logic [4:0] OFS_ENABLE = 5'h03;
   localparam logic [4:0] OFS_CNTRL1 = 5'h04;
   localparam logic [4:0] OFS_CNTRL2 = 5'h05;
   // field positions, register reset value and soft off sleep type
   localparam int BIT_PB_FLAG = 0;
   localparam int BIT_OVR_FLAG = 3;
   localparam int BIT_WAKE_FLAG = 7;
   localparam int BIT_PB_SCI_GLOBAL_ENABLE = 0;
   localparam int BIT_SCI_GLOBAL = 0;
   localparam int BIT_OVR_EN = 1;
   localparam int BIT_SLP_TYPE_LO = 2;
   localparam int BIT_SLP_EN = 5;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [2:0] SLP_TYPE_OFF = 3'h0;
   // timing
   localparam int REF_CLK_HZ = 10_000_000;
   localparam int STBY_CLK_HZ = 32_000;
   localparam int STBY_DIV = REF_CLK_HZ / STBY_CLK_HZ;
   localparam int OVR_HOLD_S = 4;
   localparam int OVR_HOLD_TICKS = OVR_HOLD_S * STBY_CLK_HZ;
   localparam int SLP_DELAY_TICKS = 1;
   typedef enum logic [1:0] {APBWS_WORKING, APBWS_SLEEP, APBWS_SOFT_OFF} apbws_pstate_t;
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } apbws_bus_t;
endpackage

// *** verilog/apbws_div.sv ***
// standby tick divider: one-cycle enable at the 32 kHz standby rate
`timescale 1ns/1ps
module apbws_div
#(
   parameter int DIV = apbws_pkg::STBY_DIV
)
(
   input wire logic ref_clk,
   input wire logic srst,
   output logic tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } apbws_div_st_t;
   apbws_div_st_t s_q, s_d;
   ////////////////////////////////////////////////////////////////////////
   // free running counter, never gated by power state
   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 16'(DIV - 1))
      begin
         s_d.cnt = 16'h0000;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign tick = s_q.tick;
endmodule // apbws_div

// *** verilog/apbws_sync.sv ***
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module apbws_sync
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic meta;
      logic stable;
   } apbws_sync_st_t;
   apbws_sync_st_t s_q, s_d;
   ////////////////////////////////////////////////////////////////////////
   // first stage feeds only the second stage
   always_comb
   begin
      s_d.meta = din;
      s_d.stable = s_q.meta;
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign dout = s_q.stable;
endmodule // apbws_sync

// *** verilog/apbws_top.sv ***
// power button and wake status block with its control registers
// What this block does
// - button press sets power button flag unless override has fired in this hold
// - working, flag and enable raise SCI
// - sleeping or off, press makes wake event
// - press always drives power on active
// - flag hardware set, write one clears
// - four second hold forces soft off
// - override flag set by override, write-one clear
// - enabled wake event while sleeping sets wake
// - power on falling edge sets wake flag
// - wake select adds enabled wake events
// - wake clear honoured only while power on low
// - wake flag set moves system to working
// - reserved bits read as zero
// - eight bit registers reset to zero
// - enable bit zero gates button SCI
// - global SCI enable gates SCI output
// - override enable at control two bit one
`timescale 1ns/1ps
module apbws_top
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [4:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic button_in,
   input wire logic wake_event_in,
   input wire logic wake_select_control,
   output logic power_on_out_n,
   output logic power_on_out_oe,
   output logic sci_out,
   output logic [1:0] power_state
);
   typedef struct packed {
      logic power_button_flag;
      logic override_flag;
      logic wake_flag;
      logic power_button_sci_enable;
      logic sci_global_enable;
      logic override_enable;
      logic [2:0] slp_type;
      logic slp_pending;
      logic [1:0] slp_ticks;
      apbws_pkg::apbws_pstate_t pstate;
      logic button_q;
      logic pwr_on_n_q;
      logic ovr_done;
      logic [17:0] hold_cnt;
      logic [7:0] rdata;
      logic sci;
   } apbws_st_t;
   apbws_st_t s_q, s_d;
   apbws_pkg::apbws_bus_t bus;
   logic button_s;
   logic stby_tick;
   logic pon_n;
   logic pon_fall;
   logic wr_status, wr_enable, wr_cntrl1, wr_cntrl2;
   logic press_edge;
   logic hold_expired;
   logic wake_evt;
   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser and standby tick
   apbws_sync u_btn_sync
   (
      .ref_clk(ref_clk),
      .srst(srst),
      .din(button_in),
      .dout(button_s)
   );
   apbws_div u_stby_div
   (
      .ref_clk(ref_clk),
      .srst(srst),
      .tick(stby_tick)
   );
   ////////////////////////////////////////////////////////////////////////
   // bus carrier and strobes
   assign bus.addr = bus_addr;
   assign bus.wdata = bus_wdata;
   assign bus.wr = bus_wr;
   assign bus.rd = bus_rd;
   assign wr_status = bus.wr && (bus.addr == apbws_pkg::OFS_STATUS);
   assign wr_enable = bus.wr && (bus.addr == apbws_pkg::OFS_ENABLE);
   assign wr_cntrl1 = bus.wr && (bus.addr == apbws_pkg::OFS_CNTRL1);
   assign wr_cntrl2 = bus.wr && (bus.addr == apbws_pkg::OFS_CNTRL2);
   ////////////////////////////////////////////////////////////////////////
   // power on is active (low) only in working state; it floats otherwise
   assign pon_n = (s_q.pstate != apbws_pkg::APBWS_WORKING);
   assign pon_fall = s_q.pwr_on_n_q && !pon_n;
   assign press_edge = button_s && !s_q.button_q;
   // hold window uses the standby tick so it runs in every power state
   assign hold_expired = (s_q.hold_cnt == 18'(apbws_pkg::OVR_HOLD_TICKS));
   // external enabled wake events only count while sleeping or in soft off
   assign wake_evt = wake_event_in && (s_q.pstate != apbws_pkg::APBWS_WORKING);
   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      s_d = s_q;
      s_d.button_q = button_s;
      s_d.pwr_on_n_q = pon_n;
      // button hold counter and override
      if (!button_s)
      begin
         s_d.hold_cnt = '0;
         s_d.ovr_done = 1'b0;
      end
      else if (stby_tick && !hold_expired)
      begin
         s_d.hold_cnt = s_q.hold_cnt + 18'h00001;
      end
      // software write-one clears, hardware sets below win over them
      if (wr_status)
      begin
         if (bus.wdata[apbws_pkg::BIT_PB_FLAG])
            s_d.power_button_flag = 1'b0;
         if (bus.wdata[apbws_pkg::BIT_OVR_FLAG])
            s_d.override_flag = 1'b0;
         if (bus.wdata[apbws_pkg::BIT_WAKE_FLAG] && !pon_n)
            s_d.wake_flag = 1'b0;
      end
      if (wr_enable)
         s_d.power_button_sci_enable = bus.wdata[apbws_pkg::BIT_PB_SCI_GLOBAL_ENABLE];
      if (wr_cntrl1)
         s_d.sci_global_enable = bus.wdata[apbws_pkg::BIT_SCI_GLOBAL];
      if (wr_cntrl2)
      begin
         s_d.override_enable = bus.wdata[apbws_pkg::BIT_OVR_EN];
         s_d.slp_type = bus.wdata[apbws_pkg::BIT_SLP_TYPE_LO +: 3];
         if (bus.wdata[apbws_pkg::BIT_SLP_EN])
         begin
            s_d.slp_pending = 1'b1;
            s_d.slp_ticks = '0;
         end
      end
      // button flag set regardless of enable
      if (button_s && !s_q.ovr_done)
         s_d.power_button_flag = 1'b1;
      // press wakes the machine whatever the enable
      if (press_edge && (s_q.pstate != apbws_pkg::APBWS_WORKING))
         s_d.pstate = apbws_pkg::APBWS_WORKING;
      // enabled wake event in sleep or soft off: sets flag only with wake select set
      if (wake_evt)
      begin
         s_d.pstate = apbws_pkg::APBWS_WORKING;
         if (wake_select_control)
            s_d.wake_flag = 1'b1;
      end
      if (pon_fall)
         s_d.wake_flag = 1'b1;
      if (s_q.wake_flag && !s_q.pwr_on_n_q && s_q.pstate != apbws_pkg::APBWS_WORKING)
         s_d.pstate = apbws_pkg::APBWS_WORKING;
      if (s_q.wake_flag && s_q.pstate == apbws_pkg::APBWS_SLEEP)
         s_d.pstate = apbws_pkg::APBWS_WORKING;
      // sleep request after one to two standby ticks
      if (s_q.slp_pending && stby_tick)
      begin
         if (s_q.slp_ticks == 2'(apbws_pkg::SLP_DELAY_TICKS))
         begin
            s_d.slp_pending = 1'b0;
            s_d.pstate = (s_q.slp_type == apbws_pkg::SLP_TYPE_OFF) ?
               apbws_pkg::APBWS_SOFT_OFF : apbws_pkg::APBWS_SLEEP;
         end
         else
         begin
            s_d.slp_ticks = s_q.slp_ticks + 2'h1;
         end
      end
      // override fires once per hold; it beats every other transition
      if (s_q.override_enable && button_s && hold_expired && !s_q.ovr_done)
      begin
         s_d.ovr_done = 1'b1;
         s_d.power_button_flag = 1'b0;
         s_d.override_flag = 1'b1;
         s_d.pstate = apbws_pkg::APBWS_SOFT_OFF;
         s_d.slp_pending = 1'b0;
      end
      // SCI only in working state, gated by both enables
      s_d.sci = (s_q.pstate == apbws_pkg::APBWS_WORKING) && s_q.power_button_flag
         && s_q.power_button_sci_enable
         && s_q.sci_global_enable;
      // registered read data, reserved bits zero
      s_d.rdata = 8'h00;
      if (bus.rd)
      begin
         unique case (bus.addr)
            apbws_pkg::OFS_STATUS:
            begin
               s_d.rdata[apbws_pkg::BIT_PB_FLAG] = s_q.power_button_flag;
               s_d.rdata[apbws_pkg::BIT_OVR_FLAG] = s_q.override_flag;
               s_d.rdata[apbws_pkg::BIT_WAKE_FLAG] = s_q.wake_flag;
            end
            apbws_pkg::OFS_ENABLE:
               s_d.rdata[apbws_pkg::BIT_PB_SCI_GLOBAL_ENABLE] = s_q.power_button_sci_enable;
            apbws_pkg::OFS_CNTRL1:
               s_d.rdata[apbws_pkg::BIT_SCI_GLOBAL] = s_q.sci_global_enable;
            apbws_pkg::OFS_CNTRL2:
            begin
               s_d.rdata[apbws_pkg::BIT_OVR_EN] = s_q.override_enable;
               s_d.rdata[apbws_pkg::BIT_SLP_TYPE_LO +: 3] = s_q.slp_type;
            end
            default:
               s_d.rdata = 8'h00; // enable one and unmapped read zero
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // state register; srst stands for the battery power-on reset
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         s_q <= '0;
         s_q.pstate <= apbws_pkg::APBWS_SOFT_OFF;
         s_q.pwr_on_n_q <= 1'b1;
         s_q.rdata <= apbws_pkg::REG_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign bus_rdata = s_q.rdata;
   assign power_on_out_n = 1'b0; // driven low when enabled, else floats
   assign power_on_out_oe = !s_q.pwr_on_n_q;
   assign sci_out = s_q.sci;
   assign power_state = s_q.pstate;
endmodule // apbws_top

// *** sim/apbws_properties.sv ***
// assertion checker of the power button and wake status block
`timescale 1ns/1ps
module apbws_properties
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [4:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic button_in,
   input wire logic wake_event_in,
   input wire logic wake_select_control,
   input wire logic power_on_out_n,
   input wire logic power_on_out_oe,
   input wire logic sci_out,
   input wire logic [1:0] power_state
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // register read-back checks, then outputs at reset release
   property p_rsvd_reg; bus_rd && bus_addr == 5'h02 |=> bus_rdata == 8'h00; endproperty
   a_rsvd_reg: assert property (p_rsvd_reg) else $error("reserved register not zero");
   property p_en_rsvd; bus_rd && bus_addr == 5'h03 |=> bus_rdata[7:1] == 7'h00; endproperty
   a_en_rsvd: assert property (p_en_rsvd) else $error("enable reserved bits set");
   property p_rel; $fell(srst) |-> !sci_out && !power_on_out_oe && power_state == 2'h2; endproperty
   a_rel: assert property (p_rel) else $error("outputs wrong after reset");
   // sci lags the state by one cycle, so either this or the last state may be working
   property p_sci_work;
      sci_out |-> power_state == 2'h0 || $past(power_state) == 2'h0;
   endproperty
   a_sci_work: assert property (p_sci_work) else $error("sci outside working state");
   // a held press reaches the working state and drives the pin
   property p_press_wake;
      $rose(button_in) ##1 button_in [*7] |-> ##[0:4] power_state == 2'h0 && power_on_out_oe;
   endproperty
   a_press_wake: assert property (p_press_wake) else $error("press did not wake");
   property p_off_float; power_state == 2'h2 [*3] |-> !power_on_out_oe; endproperty
   a_off_float: assert property (p_off_float) else $error("pin driven in soft off");
   property p_work_drive; power_state == 2'h0 [*3] |-> power_on_out_oe; endproperty
   a_work_drive: assert property (p_work_drive) else $error("pin not driven in working");
   property p_wake_sel;
      wake_event_in && wake_select_control && power_state == 2'h1 |-> ##[1:4] power_state == 2'h0;
   endproperty
   a_wake_sel: assert property (p_wake_sel) else $error("wake event ignored");
endmodule // apbws_properties
bind apbws_top apbws_properties apbws_properties_i (.ref_clk, .srst, .bus_addr, .bus_wdata,
   .bus_wr, .bus_rd, .bus_rdata, .button_in, .wake_event_in, .wake_select_control,
   .power_on_out_n, .power_on_out_oe, .sci_out, .power_state);

// *** sim/apbws_partner.sv ***
// model of the power button switch and the supply that follows the power on pin
`timescale 1ns/1ps
module apbws_partner
(
   input wire logic ref_clk,
   input wire logic power_on_out_n,
   input wire logic power_on_out_oe,
   output logic button_in,
   output logic supply_on
);
   logic pin_level;
   // open drain pin with a pull-up: a floating pin reads high
   assign pin_level = power_on_out_oe ? power_on_out_n : 1'b1;
   assign supply_on = !pin_level;
   initial button_in = 1'b0;
   // switch held for a number of cycles, moved off the sampling edge
   task automatic press(input int hold);
      @(negedge ref_clk);
      button_in = 1'b1;
      repeat (hold) @(negedge ref_clk);
      button_in = 1'b0;
   endtask
endmodule // apbws_partner

// *** sim/tb.sv ***
// self-checking testbench of the power button and wake status block
`timescale 1ns/1ps
module tb;
   typedef struct packed {logic [4:0] a; logic [7:0] d; logic w; logic [7:0] e;} apbws_row_t;
   logic ref_clk, srst, bus_wr, bus_rd, wake_event_in, wake_select_control;
   logic [4:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata;
   logic power_on_out_n, power_on_out_oe, sci_out, button_in, supply_on;
   logic [1:0] power_state;
   int n_fail = 0;
   int check_count = 0;
   // reset values first, then writes that keep reserved bits at zero
   apbws_row_t rows [12] = '{'{5'h01, 8'h00, 1'b0, 8'h00}, '{5'h02, 8'h00, 1'b0, 8'h00},
      '{5'h03, 8'h00, 1'b0, 8'h00}, '{5'h04, 8'h00, 1'b0, 8'h00}, '{5'h05, 8'h00, 1'b0, 8'h00},
      '{5'h06, 8'h00, 1'b0, 8'h00}, '{5'h03, 8'h01, 1'b1, 8'h01}, '{5'h02, 8'h00, 1'b1, 8'h00},
      '{5'h05, 8'h02, 1'b1, 8'h02}, '{5'h05, 8'h00, 1'b1, 8'h00}, '{5'h03, 8'h00, 1'b1, 8'h00},
      '{5'h04, 8'h01, 1'b1, 8'h01}};
   apbws_top apbws_top_i (.ref_clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
      .button_in, .wake_event_in, .wake_select_control, .power_on_out_n, .power_on_out_oe,
      .sci_out, .power_state);
   apbws_partner apbws_partner_i (.ref_clk, .power_on_out_n, .power_on_out_oe, .button_in,
      .supply_on);
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle strobes, launched and dropped at falling edges
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge ref_clk);
      bus_wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge ref_clk);
      bus_rd = 1'b0;
      chk(bus_rdata, exp);
   endtask
   // sleep entry takes up to two standby ticks, so the bound is generous
   task automatic wait_state(input logic [1:0] s);
      int i;
      for (i = 0; i < 1000 && power_state !== s; i++)
         @(negedge ref_clk);
      if (power_state !== s)
      begin
         n_fail++;
         $display("BAD %0t state wait timeout", $time);
         end_of_test();
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      srst = 1'b1;
      bus_addr = 5'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      wake_event_in = 1'b0;
      wake_select_control = 1'b0;
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      foreach (rows[i])
      begin
         if (rows[i].w)
            wr_reg(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      // press from soft off with the button enable clear
      apbws_partner_i.press(20);
      wait_state(2'h0);
      chk({7'h00, supply_on}, 8'h01);
      rd_chk(5'h01, 8'h81);
      chk({7'h00, sci_out}, 8'h00);
      wr_reg(5'h03, 8'h01);
      repeat (3) @(negedge ref_clk);
      chk({7'h00, sci_out}, 8'h01);
      wr_reg(5'h04, 8'h00);
      repeat (3) @(negedge ref_clk);
      chk({7'h00, sci_out}, 8'h00);
      wr_reg(5'h01, 8'h00);
      rd_chk(5'h01, 8'h81);
      wr_reg(5'h01, 8'h01);
      rd_chk(5'h01, 8'h80);
      wr_reg(5'h01, 8'h80);
      rd_chk(5'h01, 8'h00);
      // non-zero sleep type, then an enabled event with wake select set
      wr_reg(5'h05, 8'h24);
      wait_state(2'h1);
      // the pin follows the state register one cycle later
      @(negedge ref_clk);
      chk({7'h00, supply_on}, 8'h00);
      wake_select_control = 1'b1;
      wake_event_in = 1'b1;
      @(negedge ref_clk);
      wake_event_in = 1'b0;
      wait_state(2'h0);
      rd_chk(5'h01, 8'h80);
      // mid-run reset clears every register and returns to soft off
      srst = 1'b1;
      wake_select_control = 1'b0;
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      chk({6'h00, power_state}, 8'h02);
      chk({7'h00, supply_on}, 8'h00);
      rd_chk(5'h01, 8'h00);
      rd_chk(5'h03, 8'h00);
      // press with wake select clear: only the power on fall sets the wake flag
      apbws_partner_i.press(20);
      wait_state(2'h0);
      rd_chk(5'h01, 8'h81);
      end_of_test();
   end
   // hang guard
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      n_fail++;
      $display("BAD %0t run timeout", $time);
      end_of_test();
   end
endmodule // tb
